// File: src/sesr_pkg.sv
// Constants, types and reset state of the standard event status reporting block
package sesr_pkg;
    // Header characters
    localparam logic [7:0] CH_STAR = 8'h2A;
    localparam logic [7:0] CH_QMARK = 8'h3F;
    localparam logic [7:0] CH_NONE = 8'h00;

    // Accepted common headers: ten mandatory, five optional
    localparam int NUM_HDR = 15;
    localparam logic [23:0] HDR_NAMES [NUM_HDR] = '{
        24'h434C53, 24'h455345, 24'h455352, 24'h49444E, 24'h4F5043,
        24'h525354, 24'h535245, 24'h535442, 24'h545354, 24'h574149,
        24'h505343, 24'h52434C, 24'h534156, 24'h545247, 24'h4F5054};
    localparam logic [3:0] IDX_CLEAR = 4'h0;
    localparam logic [3:0] IDX_ENABLE = 4'h1;
    localparam logic [3:0] IDX_EVREAD = 4'h2;
    localparam logic [3:0] IDX_OPDONE = 4'h4;
    localparam logic [3:0] IDX_SBYTE = 4'h7;
    localparam logic [3:0] IDX_PSCLR = 4'hA;

    // Standard event bit positions
    localparam int B_PON = 7;
    localparam int B_CME = 5;
    localparam int B_EXE = 4;
    localparam int B_DDE = 3;
    localparam int B_QYE = 2;
    localparam int B_OPC = 0;
    localparam logic [7:0] EVT_USED = 8'hBD;

    // Status byte bit positions
    localparam int SB_ERRQ = 2;
    localparam int SB_QUES = 3;
    localparam int SB_MAV = 4;
    localparam int SB_ESB = 5;
    localparam int SB_OPER = 7;

    // Reset values and start-up wait
    localparam logic [7:0] EVT_RESET = 8'h80;
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [1:0] BOOT_CYCLES = 2'h3;

    typedef enum logic [1:0] {
        SESR_BOOT = 2'b01,
        SESR_RUN = 2'b10
    } sesr_phase_t;

    typedef struct packed {
        sesr_phase_t phase;
        logic [1:0] boot_cnt;
        logic [7:0] evt;
        logic [7:0] en;
        logic psc;
        logic opc_armed;
        logic [7:0] stb;
        logic resp_valid;
        logic [7:0] resp_data;
        logic clr_ext;
        logic clr_outq;
        logic nv_wr;
        logic [7:0] nv_en;
        logic nv_psc;
        logic pass_valid;
        logic [3:0] pass_idx;
        logic pass_query;
    } sesr_state_t;

    localparam sesr_state_t ST_RESET = '{
        phase: SESR_BOOT, boot_cnt: 2'h0, evt: EVT_RESET, en: EN_RESET, psc: 1'b1,
        opc_armed: 1'b0, stb: 8'h00, resp_valid: 1'b0, resp_data: 8'h00,
        clr_ext: 1'b0, clr_outq: 1'b0, nv_wr: 1'b0, nv_en: 8'h00, nv_psc: 1'b0,
        pass_valid: 1'b0, pass_idx: 4'h0, pass_query: 1'b0};
endpackage : sesr_pkg

// File: src/sesr_sync3.sv
// Three-stage synchroniser for levels arriving from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module sesr_sync3 #(
    parameter int W = 9
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] o;
    } sesr_sync_t;

    sesr_sync_t st_q;
    sesr_sync_t st_d;

    // A bit moves only once stages two and three agree; stage one feeds stage two only
    // The agreed level is offered in the same cycle, so the boot load sees it in time
    always_comb begin
        st_d = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.o = (~(st_q.s2 ^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.o);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_d.o;
endmodule : sesr_sync3
`default_nettype wire

// File: src/sesr_status.sv
// Standard event status reporting: common command decode, event and enable registers
`timescale 1ns/10ps
`default_nettype none
module sesr_status (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Common command from the parser
    input wire logic cmd_valid,
    input wire logic [39:0] cmd_hdr,
    input wire logic cmd_first,
    input wire logic [7:0] cmd_param,
    // Event sources on this clock
    input wire logic ev_dev_err,
    input wire logic ev_exe_err,
    input wire logic ev_qry_err,
    input wire logic pend_busy,
    input wire logic mav_in,
    input wire logic errq_nonempty,
    input wire logic oper_sum,
    input wire logic ques_sum,
    // Nonvolatile storage contents, outside the clock domain
    input wire logic nv_psc_in,
    input wire logic [7:0] nv_en_in,
    // Query answers
    output logic resp_valid,
    output logic [7:0] resp_data,
    // Clear pulses to neighbours
    output logic clr_ext,
    output logic clr_outq,
    // Nonvolatile write request
    output logic nv_wr,
    output logic [7:0] nv_en_data,
    output logic nv_psc_data,
    // Commands handled elsewhere
    output logic pass_valid,
    output logic [3:0] pass_idx,
    output logic pass_query,
    // Register views
    output logic [7:0] status_byte,
    output logic [7:0] event_reg,
    output logic [7:0] enable_reg
);
    sesr_pkg::sesr_state_t st_q;
    sesr_pkg::sesr_state_t st_d;
    logic [8:0] nv_sync;
    logic [sesr_pkg::NUM_HDR-1:0] hdr_hit;
    logic hdr_ok;
    logic is_query;
    logic [3:0] hit_idx;
    logic any_hit;

    // Stored settings cross in through three stages
    sesr_sync3 #(
        .W(9)
    ) u_nv_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in({nv_psc_in, nv_en_in}),
        .sync_out(nv_sync)
    );

    // One comparator per accepted header
    for (genvar i = 0; i < sesr_pkg::NUM_HDR; i++) begin : g_hdr
        assign hdr_hit[i] = (cmd_hdr[31:8] == sesr_pkg::HDR_NAMES[i]);
    end

    // Syntax: leading asterisk, optional trailing question mark
    assign is_query = (cmd_hdr[7:0] == sesr_pkg::CH_QMARK);
    assign hdr_ok = (cmd_hdr[39:32] == sesr_pkg::CH_STAR)
        && (is_query || (cmd_hdr[7:0] == sesr_pkg::CH_NONE));

    // Header index, lowest match wins
    always_comb begin
        hit_idx = 4'h0;
        any_hit = 1'b0;
        for (int k = sesr_pkg::NUM_HDR - 1; k >= 0; k--) begin
            if (hdr_hit[k]) begin
                hit_idx = 4'(k);
                any_hit = 1'b1;
            end
        end
    end

    // Next state of the whole block
    always_comb begin
        logic [7:0] ev_set;
        logic do_cmd;
        logic bad_hdr;
        ev_set = sesr_pkg::BYTE_ZERO;
        do_cmd = cmd_valid && (st_q.phase == sesr_pkg::SESR_RUN);
        bad_hdr = do_cmd && !(hdr_ok && any_hit);
        st_d = st_q;
        st_d.resp_valid = 1'b0;
        st_d.clr_ext = 1'b0;
        st_d.clr_outq = 1'b0;
        st_d.nv_wr = 1'b0;
        st_d.pass_valid = 1'b0;
        case (st_q.phase)
            sesr_pkg::SESR_BOOT: begin
                // Wait until the stored settings have crossed over
                st_d.boot_cnt = 2'(st_q.boot_cnt + 2'h1);
                if (st_q.boot_cnt == sesr_pkg::BOOT_CYCLES) begin
                    st_d.phase = sesr_pkg::SESR_RUN;
                    st_d.psc = nv_sync[8];
                    st_d.en = nv_sync[8] ? sesr_pkg::EN_RESET : nv_sync[7:0];
                end
            end
            sesr_pkg::SESR_RUN: begin
                if (do_cmd && !bad_hdr) begin
                    if (hit_idx == sesr_pkg::IDX_CLEAR && !is_query) begin
                        st_d.evt = sesr_pkg::BYTE_ZERO;
                        st_d.clr_ext = 1'b1;
                        st_d.clr_outq = cmd_first;
                        st_d.opc_armed = 1'b0;
                    end else if (hit_idx == sesr_pkg::IDX_ENABLE && !is_query) begin
                        st_d.en = cmd_param;
                        st_d.nv_wr = !st_q.psc;
                        st_d.nv_en = cmd_param;
                        st_d.nv_psc = st_q.psc;
                    end else if (hit_idx == sesr_pkg::IDX_ENABLE) begin
                        st_d.resp_valid = 1'b1;
                        st_d.resp_data = st_q.en;
                    end else if (hit_idx == sesr_pkg::IDX_EVREAD && is_query) begin
                        st_d.resp_valid = 1'b1;
                        st_d.resp_data = st_q.evt;
                        st_d.evt = sesr_pkg::BYTE_ZERO;
                    end else if (hit_idx == sesr_pkg::IDX_SBYTE && is_query) begin
                        st_d.resp_valid = 1'b1;
                        st_d.resp_data = st_q.stb;
                    end else if (hit_idx == sesr_pkg::IDX_PSCLR && !is_query) begin
                        // Any nonzero parameter means clear at power-on
                        st_d.psc = |cmd_param;
                        st_d.nv_wr = 1'b1;
                        st_d.nv_en = st_q.en;
                        st_d.nv_psc = |cmd_param;
                    end else if (hit_idx == sesr_pkg::IDX_PSCLR) begin
                        st_d.resp_valid = 1'b1;
                        st_d.resp_data = {7'h00, st_q.psc};
                    end else if (hit_idx == sesr_pkg::IDX_OPDONE && !is_query) begin
                        st_d.opc_armed = 1'b1;
                    end else begin
                        st_d.pass_valid = 1'b1;
                        st_d.pass_idx = hit_idx;
                        st_d.pass_query = is_query;
                    end
                end
            end
            default: begin
                st_d.phase = sesr_pkg::SESR_BOOT;
            end
        endcase
        // Events from this and other blocks, masked to the legal positions
        ev_set[sesr_pkg::B_CME] = bad_hdr;
        ev_set[sesr_pkg::B_EXE] = ev_exe_err;
        ev_set[sesr_pkg::B_DDE] = ev_dev_err;
        ev_set[sesr_pkg::B_QYE] = ev_qry_err;
        ev_set[sesr_pkg::B_OPC] = st_q.opc_armed && !pend_busy;
        if (ev_set[sesr_pkg::B_OPC]) begin
            st_d.opc_armed = 1'b0;
        end
        // Setting wins over a clear in the same cycle
        st_d.evt = (st_d.evt | ev_set) & sesr_pkg::EVT_USED;
        // Status byte follows its sources; cleared sources make it read zero
        st_d.stb = sesr_pkg::BYTE_ZERO;
        st_d.stb[sesr_pkg::SB_ERRQ] = errq_nonempty && !st_d.clr_ext;
        st_d.stb[sesr_pkg::SB_QUES] = ques_sum && !st_d.clr_ext;
        st_d.stb[sesr_pkg::SB_MAV] = mav_in && !st_d.clr_outq;
        st_d.stb[sesr_pkg::SB_ESB] = |(st_d.evt & st_d.en);
        st_d.stb[sesr_pkg::SB_OPER] = oper_sum && !st_d.clr_ext;
    end

    // Single register stage for all state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= sesr_pkg::ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign resp_valid = st_q.resp_valid;
    assign resp_data = st_q.resp_data;
    assign clr_ext = st_q.clr_ext;
    assign clr_outq = st_q.clr_outq;
    assign nv_wr = st_q.nv_wr;
    assign nv_en_data = st_q.nv_en;
    assign nv_psc_data = st_q.nv_psc;
    assign pass_valid = st_q.pass_valid;
    assign pass_idx = st_q.pass_idx;
    assign pass_query = st_q.pass_query;
    assign status_byte = st_q.stb;
    assign event_reg = st_q.evt;
    assign enable_reg = st_q.en;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic run_q;
    assign run_q = (st_q.phase == sesr_pkg::SESR_RUN);

    a_summary_tracks: assert property (
        status_byte[sesr_pkg::SB_ESB] == |(event_reg & enable_reg))
        else $error("summary bit disagrees with events and enables");
    a_reserved_zero: assert property (
        event_reg[6] == 1'b0 && event_reg[1] == 1'b0)
        else $error("reserved event bit set");
    a_clear_events: assert property (
        cmd_valid && run_q && cmd_hdr == {sesr_pkg::CH_STAR, 24'h434C53, sesr_pkg::CH_NONE}
        && !ev_exe_err && !ev_dev_err && !ev_qry_err && !pend_busy
        |=> event_reg == {7'h00, $past(st_q.opc_armed)} && clr_ext)
        else $error("clear-status left events set");
    a_outq_first: assert property (
        clr_outq |-> clr_ext && !status_byte[sesr_pkg::SB_MAV])
        else $error("output queue clear without status clear");
    a_enable_write: assert property (
        cmd_valid && run_q && cmd_hdr == {sesr_pkg::CH_STAR, 24'h455345, sesr_pkg::CH_NONE}
        |=> enable_reg == $past(cmd_param) && nv_wr == !$past(st_q.psc))
        else $error("enable write not stored");
    a_nv_copy: assert property (
        nv_wr && !$past(cmd_hdr[15:8] == 8'h43) |-> nv_en_data == enable_reg)
        else $error("stored copy differs from enable");
    a_read_clears: assert property (
        cmd_valid && run_q && cmd_hdr == {sesr_pkg::CH_STAR, 24'h455352, sesr_pkg::CH_QMARK}
        && !ev_exe_err && !ev_dev_err && !ev_qry_err && !pend_busy
        |=> resp_valid && resp_data == $past(event_reg)
        && event_reg == {7'h00, $past(st_q.opc_armed)})
        else $error("event read did not return and clear");
    a_bad_header: assert property (
        cmd_valid && run_q && cmd_hdr[39:32] != sesr_pkg::CH_STAR
        |=> event_reg[sesr_pkg::B_CME])
        else $error("bad header not flagged");
    a_opc_done: assert property (
        st_q.opc_armed && !pend_busy |=> event_reg[sesr_pkg::B_OPC] && !st_q.opc_armed)
        else $error("operation complete not flagged");
    a_boot_load: assert property (
        st_q.phase == sesr_pkg::SESR_BOOT ##1 run_q |-> enable_reg == (st_q.psc ? 8'h00
        : $past(nv_sync[7:0])))
        else $error("start-up enable load wrong");

    c_clear_first: cover property (clr_outq);
    c_event_read: cover property (resp_valid && resp_data != 8'h00);
    c_summary_set: cover property (status_byte[sesr_pkg::SB_ESB]);
    c_nv_write: cover property (nv_wr);
endmodule : sesr_status
`default_nettype wire

// File: test/sesr_host_model.sv
// Host controller model issuing common command units to the status block
`timescale 1ns/10ps
`default_nettype none
module sesr_host_model (
    // Clock
    input wire logic clk,
    // Command unit
    output logic cmd_valid,
    output logic [39:0] cmd_hdr,
    output logic cmd_first,
    output logic [7:0] cmd_param
);
    // Idle values before the first unit
    initial begin
        cmd_valid = 1'b0;
        cmd_hdr = 40'h0000000000;
        cmd_first = 1'b0;
        cmd_param = 8'h00;
    end

    // One unit per strobe; released lines are inverted so stale data never looks valid
    task automatic send(input logic [23:0] name, input logic qry, input logic first,
                        input logic [7:0] param);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_hdr = {sesr_pkg::CH_STAR, name, qry ? sesr_pkg::CH_QMARK : sesr_pkg::CH_NONE};
        cmd_first = first;
        cmd_param = param;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_hdr = ~cmd_hdr;
        cmd_first = ~cmd_first;
        cmd_param = ~cmd_param;
    endtask : send
endmodule : sesr_host_model
`default_nettype wire

// File: test/tb_standard_event_status_reporting.sv
// Self-checking bench for the standard event status reporting block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_standard_event_status_reporting;
    localparam int H_CLR = 0;
    localparam int H_EN = 1;
    localparam int H_EVR = 2;
    localparam int H_IDN = 3;
    localparam int H_STB = 7;
    localparam int H_DONE = 4;
    localparam int H_PSC = 10;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid, cmd_first;
    logic [39:0] cmd_hdr;
    logic [7:0] cmd_param;
    logic ev_dev_err = 1'b0, ev_exe_err = 1'b0, ev_qry_err = 1'b0, pend_busy = 1'b0;
    logic mav_in = 1'b0, errq_nonempty = 1'b0, oper_sum = 1'b0, ques_sum = 1'b0;
    logic nv_psc_in = 1'b1;
    logic [7:0] nv_en_in = 8'h00;
    logic resp_valid, clr_ext, clr_outq, nv_wr, nv_psc_data, pass_valid, pass_query;
    logic [7:0] resp_data, nv_en_data, status_byte, event_reg, enable_reg;
    logic [3:0] pass_idx;
    int bad_count = 0;
    int checks = 0;

    // 250 MHz clock
    always #2 clk = ~clk;

    sesr_host_model i_sesr_host_model (.clk(clk), .cmd_valid(cmd_valid), .cmd_hdr(cmd_hdr),
        .cmd_first(cmd_first), .cmd_param(cmd_param));

    sesr_status i_sesr_status (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_hdr(cmd_hdr), .cmd_first(cmd_first), .cmd_param(cmd_param),
        .ev_dev_err(ev_dev_err), .ev_exe_err(ev_exe_err), .ev_qry_err(ev_qry_err),
        .pend_busy(pend_busy), .mav_in(mav_in), .errq_nonempty(errq_nonempty),
        .oper_sum(oper_sum), .ques_sum(ques_sum), .nv_psc_in(nv_psc_in), .nv_en_in(nv_en_in),
        .resp_valid(resp_valid), .resp_data(resp_data), .clr_ext(clr_ext), .clr_outq(clr_outq),
        .nv_wr(nv_wr), .nv_en_data(nv_en_data), .nv_psc_data(nv_psc_data),
        .pass_valid(pass_valid), .pass_idx(pass_idx), .pass_query(pass_query),
        .status_byte(status_byte), .event_reg(event_reg), .enable_reg(enable_reg));

    // Verdict and end of run
    task automatic finish_test();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // Reset with stored settings; waits out the boot phase before any command
    task automatic do_reset(input logic psc, input logic [7:0] en);
        @(negedge clk);
        sys_rst = 1'b1;
        nv_psc_in = psc;
        nv_en_in = en;
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        repeat (8) @(negedge clk);
    endtask : do_reset

    task automatic send(input int h, input logic q, input logic f, input logic [7:0] p);
        i_sesr_host_model.send(sesr_pkg::HDR_NAMES[h], q, f, p);
    endtask : send

    // One-cycle event pulses; results read at the following falling edge
    task automatic pulse(input logic [2:0] dxq);
        @(negedge clk);
        {ev_dev_err, ev_exe_err, ev_qry_err} = dxq;
        @(negedge clk);
        {ev_dev_err, ev_exe_err, ev_qry_err} = 3'b000;
    endtask : pulse

    task automatic t_enable();
        send(H_EN, 1'b0, 1'b0, 8'h80);
        `CHK(enable_reg, 8'h80)
        `CHK(status_byte[5], 1'b1)
        `CHK(nv_wr, 1'b0)
        send(H_EN, 1'b0, 1'b0, 8'h7F);
        `CHK(status_byte[5], 1'b0)
        send(H_EN, 1'b1, 1'b0, 8'h00);
        `CHK(resp_valid, 1'b1)
        `CHK(resp_data, 8'h7F)
        send(H_PSC, 1'b0, 1'b0, 8'h00);
        send(H_EN, 1'b0, 1'b0, 8'hFF);
        `CHK(nv_wr, 1'b1)
        `CHK(nv_en_data, 8'hFF)
    endtask : t_enable

    task automatic t_events();
        send(H_EVR, 1'b1, 1'b0, 8'h00);
        `CHK(resp_data, 8'h80)
        `CHK(event_reg, 8'h00)
        send(H_EN, 1'b0, 1'b0, 8'h08);
        pulse(3'b011);
        `CHK(event_reg, 8'h14)
        `CHK(status_byte[5], 1'b0)
        pulse(3'b100);
        `CHK(event_reg, 8'h1C)
        `CHK(status_byte[5], 1'b1)
    endtask : t_events

    // Commands served elsewhere are handed on; an unknown header is a command error
    task automatic t_pass();
        for (int i = 0; i < sesr_pkg::NUM_HDR; i++) begin
            if (!(i inside {0, 1, 2, 4, 7, 10})) begin
                send(i, 1'b0, 1'b0, 8'h00);
                `CHK(pass_valid, 1'b1)
                `CHK(pass_idx, 4'(i))
            end
        end
        i_sesr_host_model.send(24'h5A5A5A, 1'b0, 1'b0, 8'h00);
        repeat (2) @(negedge clk);
        `CHK(event_reg[5], 1'b1)
    endtask : t_pass

    task automatic t_clear();
        send(H_CLR, 1'b0, 1'b1, 8'h00);
        `CHK(clr_ext, 1'b1)
        `CHK(clr_outq, 1'b1)
        `CHK(event_reg, 8'h00)
        @(negedge clk);
        `CHK(status_byte, 8'h00)
        send(H_CLR, 1'b0, 1'b0, 8'h00);
        `CHK(clr_outq, 1'b0)
        `CHK(clr_ext, 1'b1)
    endtask : t_clear

    // Completion flag waits for pending work, bounded wait afterwards
    task automatic t_done();
        int n;
        pend_busy = 1'b1;
        send(H_DONE, 1'b0, 1'b0, 8'h00);
        repeat (4) @(negedge clk);
        `CHK(event_reg[0], 1'b0)
        pend_busy = 1'b0;
        for (n = 0; n < 8 && event_reg[0] !== 1'b1; n++) begin
            @(negedge clk);
        end
        if (n == 8) begin
            bad_count++;
            finish_test();
        end
        `CHK(event_reg[0], 1'b1)
    endtask : t_done

    // Status byte sources, its query, both clear kinds and the remaining answers
    task automatic t_status();
        {errq_nonempty, ques_sum, mav_in, oper_sum} = 4'hF;
        @(negedge clk);
        `CHK(status_byte, 8'h9C)
        send(H_STB, 1'b1, 1'b0, 8'h00);
        `CHK(resp_data, 8'h9C)
        send(H_CLR, 1'b0, 1'b0, 8'h00);
        `CHK(status_byte, 8'h10)
        send(H_CLR, 1'b0, 1'b1, 8'h00);
        `CHK(status_byte, 8'h00)
        {errq_nonempty, ques_sum, mav_in, oper_sum} = 4'h0;
        send(H_PSC, 1'b1, 1'b0, 8'h00);
        `CHK(resp_data, 8'h00)
        send(H_PSC, 1'b0, 1'b0, 8'h01);
        `CHK(nv_psc_data, 1'b1)
        send(H_IDN, 1'b1, 1'b0, 8'h00);
        `CHK(pass_query, 1'b1)
        `CHK(pass_idx, 4'h3)
    endtask : t_status

    // Main sequence
    initial begin
        do_reset(1'b1, 8'h5A);
        `CHK(event_reg, 8'h80)
        `CHK(enable_reg, 8'h00)
        t_enable();
        t_events();
        t_pass();
        t_clear();
        t_done();
        t_status();
        do_reset(1'b0, 8'h5A);
        `CHK(enable_reg, 8'h5A)
        `CHK(event_reg, 8'h80)
        send(H_EN, 1'b0, 1'b0, 8'h11);
        `CHK(nv_wr, 1'b1)
        finish_test();
    end
endmodule : tb_standard_event_status_reporting
`default_nettype wire
